// File: rtl/ouv_top.sv
// Output undervoltage fault responder with an AXI4-Lite register slave.
// Assumes vout_meas comes from logic on aclk; power_on and bias_ok are pins.
// Function
// R1: Flag fault when output below threshold.
// R2: Code 01: run delay one, then shut down.
// R3: Code 10: shut down at once, then retry.
// R4: Code 11: hold off until fault clears.
// R5: Retry field 0 to 6, seven unlimited.
// R6: Retries used up: stay off until cleared.
// R7: Reset, power cycle, bias loss clear latch.
// R8: Wait delay two between restart attempts.
// R9: Wait delay one before disabling output.
// R10: Delay codes map to fixed millisecond times.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ouv_cfg.svh"

module ouv_top
  import ouv_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `OUV_MS_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] vout_meas,
  input  wire logic        power_on,
  input  wire logic        bias_ok,
  output logic             out_enable,
  output logic             irq
);

  ouv_tmr_if tmr ();

  ouv_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr)
  );

  logic [7:0]  action_reg;
  logic [15:0] thresh_reg;
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic [3:0]  events;
  logic        fault_reg;
  ouv_state_t  state_reg;
  logic [2:0]  used_reg;
  logic        out_en_reg;
  logic [1:0]  pwr_sync_reg;
  logic [1:0]  bias_sync_reg;
  logic        supply_ok;
  logic [1:0]  resp;
  logic [2:0]  retry;
  logic [2:0]  dsel;
  logic        may_retry;

  assign resp      = action_reg[`OUV_RESP_MSB:`OUV_RESP_LSB];
  assign retry     = action_reg[`OUV_RETRY_MSB:`OUV_RETRY_LSB];
  assign dsel      = action_reg[`OUV_DELAY_MSB:`OUV_DELAY_LSB];
  assign may_retry = ouv_can_retry(retry, used_reg);  // [R5]
  assign supply_ok = pwr_sync_reg[1] && bias_sync_reg[1];
  assign out_enable = out_en_reg;

  // Both supply pins are asynchronous to aclk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_sync_reg  <= 2'h0;
      bias_sync_reg <= 2'h0;
    end else begin
      pwr_sync_reg  <= {pwr_sync_reg[0], power_on};
      bias_sync_reg <= {bias_sync_reg[0], bias_ok};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= (vout_meas < thresh_reg);  // [R1]
    end
  end

  // Sequencer. After a restart the attempt count is only forgiven once the output has stayed
  // fault-free for a full restart interval, so a fault that keeps coming back still runs out.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= OUV_RUN;
      used_reg  <= 3'h0;
      tmr.load  <= 1'b0;
      tmr.ms    <= '0;
      events    <= 4'h0;
    end else begin
      tmr.load <= 1'b0;
      events   <= 4'h0;
      if (!supply_ok) begin
        state_reg <= OUV_RUN;  // [R7]
        used_reg  <= 3'h0;
      end else begin
        unique case (state_reg)
          OUV_RUN: begin
            if (fault_reg && resp != `OUV_RESP_IGNORE) begin
              events[`OUV_EV_FAULT] <= 1'b1;
              unique case (resp)
                `OUV_RESP_DELAYED: begin
                  state_reg <= OUV_DELAY;  // [R2]
                  tmr.load  <= 1'b1;
                  tmr.ms    <= ouv_trip_ms(dsel);  // [R9]
                end
                `OUV_RESP_HOLD: begin
                  state_reg <= OUV_HOLD;  // [R4]
                  events[`OUV_EV_SHUT] <= 1'b1;
                end
                default: begin
                  events[`OUV_EV_SHUT] <= 1'b1;  // [R3]
                  if (may_retry) begin
                    state_reg <= OUV_OFF_WAIT;
                    tmr.load  <= 1'b1;
                    tmr.ms    <= ouv_restart_ms(dsel);  // [R8]
                  end else begin
                    state_reg <= OUV_LATCH;  // [R6]
                    events[`OUV_EV_LATCH] <= 1'b1;
                  end
                end
              endcase
            end else if (tmr.done) begin
              used_reg <= 3'h0;
            end else if (used_reg != 3'h0 && !tmr.busy && !tmr.load) begin
              tmr.load <= 1'b1;
              tmr.ms   <= ouv_restart_ms(dsel);
            end
          end
          OUV_DELAY: begin
            if (!fault_reg) begin
              // A trip count still running must not end up forgiving attempts early.
              state_reg <= OUV_RUN;
              tmr.load  <= 1'b1;
              tmr.ms    <= ouv_restart_ms(dsel);
            end else if (tmr.done) begin
              events[`OUV_EV_SHUT] <= 1'b1;  // [R2] [R9]
              if (may_retry) begin
                state_reg <= OUV_OFF_WAIT;
                tmr.load  <= 1'b1;
                tmr.ms    <= ouv_restart_ms(dsel);
              end else begin
                state_reg <= OUV_LATCH;  // [R6]
                events[`OUV_EV_LATCH] <= 1'b1;
              end
            end
          end
          OUV_OFF_WAIT: begin
            if (tmr.done) begin
              state_reg <= OUV_RUN;  // [R8]
              events[`OUV_EV_RESTART] <= 1'b1;
              if (used_reg != `OUV_RETRY_INF) begin
                used_reg <= used_reg + 1'b1;  // [R5]
              end
            end
          end
          OUV_HOLD: begin
            if (!fault_reg) begin
              state_reg <= OUV_RUN;  // [R4]
              tmr.load  <= 1'b1;
              tmr.ms    <= ouv_restart_ms(dsel);
            end
          end
          OUV_LATCH: begin
            state_reg <= OUV_LATCH;  // [R6]
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_en_reg <= 1'b0;
    end else begin
      out_en_reg <= supply_ok && (state_reg == OUV_RUN || state_reg == OUV_DELAY);  // [R3] [R4]
    end
  end

  // AXI4-Lite write side: address and data are taken in either order, then one response.
  logic       aw_got_reg;
  logic       w_got_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic       wr_fire;

  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign wr_fire       = aw_got_reg && w_got_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      waddr_reg    <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OUV_AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        waddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_reg)
          `OUV_ADDR_ACTION, `OUV_ADDR_THRESH, `OUV_ADDR_STATUS,
          `OUV_ADDR_MASK, `OUV_ADDR_STATE: s_axi_bresp <= `OUV_AXI_OKAY;
          default:                         s_axi_bresp <= `OUV_AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      action_reg <= `OUV_ACTION_RST;
      thresh_reg <= `OUV_THRESH_RST;
      mask_reg   <= `OUV_MASK_RST;
    end else if (wr_fire) begin
      case (waddr_reg)
        `OUV_ADDR_ACTION: action_reg <= 8'(ouv_merge({24'h0, action_reg}, wdata_reg, wstrb_reg));
        `OUV_ADDR_THRESH: thresh_reg <= 16'(ouv_merge({16'h0, thresh_reg}, wdata_reg, wstrb_reg));
        `OUV_ADDR_MASK:   mask_reg   <= 4'(ouv_merge({28'h0, mask_reg}, wdata_reg, wstrb_reg));
        default: ;
      endcase
    end
  end

  // AXI4-Lite read side: data one cycle after the address is taken.
  logic rd_status;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_status     = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `OUV_ADDR_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OUV_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `OUV_AXI_OKAY;
      case (s_axi_araddr)
        `OUV_ADDR_ACTION: s_axi_rdata <= {24'h0, action_reg};
        `OUV_ADDR_THRESH: s_axi_rdata <= {16'h0, thresh_reg};
        `OUV_ADDR_STATUS: s_axi_rdata <= {28'h0, status_reg};
        `OUV_ADDR_MASK:   s_axi_rdata <= {28'h0, mask_reg};
        `OUV_ADDR_STATE:  s_axi_rdata <= {23'h0, used_reg, 1'b0, state_reg, out_en_reg, fault_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `OUV_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // A read clears what it returned; an event in the same cycle survives the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (rd_status ? 4'h0 : status_reg) | events;
    end
  end

  assign irq = |(status_reg & mask_reg);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fault_seen;
    supply_ok && state_reg == OUV_RUN && fault_reg;
  endsequence

  sequence s_trip_timeout;
    state_reg == OUV_DELAY && fault_reg && tmr.done && supply_ok;
  endsequence

  a_uv_detect: assert property (fault_reg == ($past(vout_meas) < $past(thresh_reg)))  // [R1]
    else $error("undervoltage flag does not follow threshold compare");
  a_delay_keeps_on: assert property (s_fault_seen ##0 resp == `OUV_RESP_DELAYED |=>  // [R2]
    state_reg == OUV_DELAY ##1 out_en_reg) else $error("delayed response dropped the output early");
  a_trip_after_delay: assert property (s_trip_timeout |=> state_reg != OUV_DELAY ##1 !out_en_reg)  // [R9]
    else $error("output not disabled after the trip delay");
  a_immediate_off: assert property (s_fault_seen ##0 resp == `OUV_RESP_RETRY |=> ##1 !out_en_reg)  // [R3]
    else $error("retry response did not shut down");
  a_hold_until_clear: assert property (state_reg == OUV_HOLD && supply_ok |=>  // [R4]
    state_reg == ($past(fault_reg) ? OUV_HOLD : OUV_RUN))
    else $error("hold response left or stuck wrongly");
  a_retry_count_ok: assert property (s_fault_seen ##0 resp == `OUV_RESP_RETRY |=>  // [R5]
    state_reg == ($past(may_retry) ? OUV_OFF_WAIT : OUV_LATCH)) else $error("retry count misdecoded");
  a_latch_stays: assert property (state_reg == OUV_LATCH && supply_ok |=> state_reg == OUV_LATCH && !out_en_reg)  // [R6]
    else $error("latched shutdown released while supplies good");
  a_supply_clears: assert property (!supply_ok |=> state_reg == OUV_RUN && used_reg == 3'h0)  // [R7]
    else $error("supply loss did not clear the latch");
  a_restart_waits: assert property ($rose(state_reg == OUV_OFF_WAIT) |-> tmr.load &&  // [R8]
    tmr.ms == ouv_restart_ms(dsel)) else $error("restart interval not started");
  a_status_irq: assert property (events != 4'h0 |=> status_reg != 4'h0)
    else $error("event lost from status");

endmodule

// File: rtl/ouv_cfg.svh
// Constants of the output undervoltage fault responder: clocking, register map, fields, delay tables.
// Assumes inclusion by the package, the rtl modules and the bench; the guard keeps one copy.
`ifndef OUV_CFG_SVH
`define OUV_CFG_SVH

`define OUV_CLK_PERIOD_NS 4
`define OUV_MS_NS         1000000
`define OUV_MS_CYCLES     (`OUV_MS_NS / `OUV_CLK_PERIOD_NS)
`define OUV_DIV_W         18
`define OUV_MS_W          12

`define OUV_ADDR_ACTION   8'h00
`define OUV_ADDR_THRESH   8'h04
`define OUV_ADDR_STATUS   8'h08
`define OUV_ADDR_MASK     8'h0c
`define OUV_ADDR_STATE    8'h10

`define OUV_ACTION_RST    8'h00
`define OUV_THRESH_RST    16'h0000
`define OUV_MASK_RST      4'h0

`define OUV_RESP_MSB      7
`define OUV_RESP_LSB      6
`define OUV_RETRY_MSB     5
`define OUV_RETRY_LSB     3
`define OUV_DELAY_MSB     2
`define OUV_DELAY_LSB     0

`define OUV_RESP_IGNORE   2'h0
`define OUV_RESP_DELAYED  2'h1
`define OUV_RESP_RETRY    2'h2
`define OUV_RESP_HOLD     2'h3
`define OUV_RETRY_INF     3'h7

`define OUV_EV_FAULT      0
`define OUV_EV_SHUT       1
`define OUV_EV_LATCH      2
`define OUV_EV_RESTART    3

`define OUV_AXI_OKAY      2'h0
`define OUV_AXI_SLVERR    2'h2

// Fault-to-shutdown delays, 10 ms to 1280 ms.
`define OUV_DT1_0 12'h00a
`define OUV_DT1_1 12'h014
`define OUV_DT1_2 12'h028
`define OUV_DT1_3 12'h050
`define OUV_DT1_4 12'h0a0
`define OUV_DT1_5 12'h140
`define OUV_DT1_6 12'h280
`define OUV_DT1_7 12'h500
// Restart intervals, 252 ms to 2604 ms.
`define OUV_DT2_0 12'h0fc
`define OUV_DT2_1 12'h22e
`define OUV_DT2_2 12'h39c
`define OUV_DT2_3 12'h4ec
`define OUV_DT2_4 12'h63c
`define OUV_DT2_5 12'h78c
`define OUV_DT2_6 12'h8dc
`define OUV_DT2_7 12'ha2c

`endif

// File: rtl/ouv_pkg.sv
// Types and helper functions of the output undervoltage fault responder.
// Assumes ouv_cfg.svh is on the include path.
`include "ouv_cfg.svh"

package ouv_pkg;

  typedef enum logic [2:0] {OUV_RUN, OUV_DELAY, OUV_OFF_WAIT, OUV_HOLD, OUV_LATCH} ouv_state_t;
  typedef logic [`OUV_MS_W-1:0] ouv_ms_t;

  function automatic ouv_ms_t ouv_trip_ms(input logic [2:0] sel);
    case (sel)
      3'h0: ouv_trip_ms = `OUV_DT1_0;
      3'h1: ouv_trip_ms = `OUV_DT1_1;
      3'h2: ouv_trip_ms = `OUV_DT1_2;
      3'h3: ouv_trip_ms = `OUV_DT1_3;
      3'h4: ouv_trip_ms = `OUV_DT1_4;
      3'h5: ouv_trip_ms = `OUV_DT1_5;
      3'h6: ouv_trip_ms = `OUV_DT1_6;
      default: ouv_trip_ms = `OUV_DT1_7;
    endcase
  endfunction

  function automatic ouv_ms_t ouv_restart_ms(input logic [2:0] sel);
    case (sel)
      3'h0: ouv_restart_ms = `OUV_DT2_0;
      3'h1: ouv_restart_ms = `OUV_DT2_1;
      3'h2: ouv_restart_ms = `OUV_DT2_2;
      3'h3: ouv_restart_ms = `OUV_DT2_3;
      3'h4: ouv_restart_ms = `OUV_DT2_4;
      3'h5: ouv_restart_ms = `OUV_DT2_5;
      3'h6: ouv_restart_ms = `OUV_DT2_6;
      default: ouv_restart_ms = `OUV_DT2_7;
    endcase
  endfunction

  // All-ones retry code never runs out of attempts.
  function automatic logic ouv_can_retry(input logic [2:0] retry, input logic [2:0] used);
    ouv_can_retry = (retry == `OUV_RETRY_INF) || (used < retry);
  endfunction

  function automatic logic [31:0] ouv_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    ouv_merge = r;
  endfunction

endpackage

// File: rtl/ouv_tmr_if.sv
// Handshake between the fault sequencer and its millisecond timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface ouv_tmr_if;
  import ouv_pkg::*;
  logic    load;
  ouv_ms_t ms;
  logic    done;
  logic    busy;
  modport ctrl  (output load, output ms, input done, input busy);
  modport timer (input load, input ms, output done, output busy);
endinterface

// File: rtl/ouv_ms_timer.sv
// Millisecond countdown timer: a divider makes a one-cycle tick each millisecond.
// Assumes a load pulse with a non-zero count; a new load restarts the count.
`timescale 1ns/1ps
`include "ouv_cfg.svh"

module ouv_ms_timer
  import ouv_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `OUV_MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  ouv_tmr_if.timer tmr
);

  localparam logic [`OUV_DIV_W-1:0] DIV_LAST = `OUV_DIV_W'(MS_CYCLES - 1);

  logic [`OUV_DIV_W-1:0] div_reg;
  ouv_ms_t               left_reg;
  logic                  busy_reg;
  logic                  done_reg;
  logic                  tick;

  assign tick     = busy_reg && (div_reg == DIV_LAST);
  assign tmr.busy = busy_reg;
  assign tmr.done = done_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else if (tmr.load || tick) begin
      div_reg <= '0;
    end else if (busy_reg) begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // Millisecond resolution derived from the core clock. [R10]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tmr.load) begin
        left_reg <= (tmr.ms == '0) ? ouv_ms_t'(1) : tmr.ms;
        busy_reg <= 1'b1;
      end else if (tick) begin
        if (left_reg == ouv_ms_t'(1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
        left_reg <= left_reg - 1'b1;
      end
    end
  end

  a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !tmr.load |=> !tick) else $error("millisecond tick repeated");  // [R10]
  a_done_from_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    done_reg |-> $past(busy_reg) && !busy_reg) else $error("timer done without a running count");  // [R10]

endmodule

// File: bench/test_output_uv_fault_response.sv
// Self-checking bench of the output undervoltage fault responder, driven through its AXI4-Lite slave and pins.
// Assumes the rtl files compile first; a millisecond is shortened to MS clock cycles.
`timescale 1ns/1ps
`include "ouv_cfg.svh"

module test_output_uv_fault_response;
  import ouv_pkg::*;
  localparam int MS = 4;
  localparam logic [15:0] V_LOW = 16'h0800;
  localparam logic [15:0] V_OK  = 16'h2000;
  logic        aclk, aresetn, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv, pwr, bias, oe, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [15:0] vm;
  int          bad_count, compares, n;
  int          cyc = 0;

  ouv_top #(.MS_CYCLES(MS)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .vout_meas(vm), .power_on(pwr), .bias_ok(bias), .out_enable(oe), .irq(irq)
  );

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The whole run needs about ten thousand cycles; twice that means a hang.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic in_rng(input string nm, input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  // Ready is sampled at the falling edge so that the next rising edge is known to complete the handshake.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(negedge aclk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv & bready;
      r = br;
      @(posedge aclk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end
    bready <= 1'h0;
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    while (!tr) begin
      @(negedge aclk);
      ta = arv & arr;
      tr = rv & rready;
      d = rd;
      r = rr;
      @(posedge aclk);
      if (ta) arv <= 1'h0;
    end
    rready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    check(nm, e, d);
    check("rresp", {30'h0, `OUV_AXI_OKAY}, {30'h0, r});
  endtask

  task automatic st_chk(input logic [2:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd_reg(`OUV_ADDR_STATE, d, r);
    check("state", {29'h0, e}, {29'h0, d[4:2]});
  endtask

  task automatic set_v(input logic [15:0] v);
    @(posedge aclk);
    vm <= v;
  endtask

  task automatic wait_oe(input logic v, input int lim, output int k);
    k = 0;
    while (oe !== v && k < lim) begin
      @(negedge aclk);
      k++;
    end
  endtask

  // Drops one supply pin for a few cycles with the fault gone, then expects the output back.
  task automatic supply_drop(input logic use_bias);
    @(posedge aclk);
    if (use_bias) bias <= 1'h0;
    else pwr <= 1'h0;
    repeat (5) @(posedge aclk);
    pwr <= 1'h1;
    bias <= 1'h1;
    wait_oe(1'h1, 30, n);
    in_rng("restore", n, 1, 10);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(`OUV_ADDR_ACTION, 32'h0, "action reset");
    rd_chk(`OUV_ADDR_MASK, 32'h0, "mask reset");
    wr_reg(`OUV_ADDR_ACTION, 32'hff, `OUV_AXI_OKAY);
    rd_chk(`OUV_ADDR_ACTION, 32'hff, "action rw");
    wr_reg(8'h14, 32'h5, `OUV_AXI_SLVERR);
    rd_reg(8'h14, d, r);
    check("unmapped", 32'h0, d);
    check("unmapped rresp", {30'h0, `OUV_AXI_SLVERR}, {30'h0, r});
    wr_reg(`OUV_ADDR_ACTION, 32'h0, `OUV_AXI_OKAY);
    wr_reg(`OUV_ADDR_THRESH, 32'h1000, `OUV_AXI_OKAY);
    rd_chk(`OUV_ADDR_THRESH, 32'h1000, "threshold");
  endtask

  task automatic t_ignore();
    logic [31:0] d;
    logic [1:0] r;
    set_v(V_LOW);
    repeat (100) @(posedge aclk);
    check("oe ignore", 32'h1, {31'h0, oe});
    rd_reg(`OUV_ADDR_STATE, d, r);
    check("fault flag", 32'h1, {31'h0, d[0]});
    set_v(16'h1000);
    repeat (4) @(posedge aclk);
    rd_reg(`OUV_ADDR_STATE, d, r);
    check("flag at limit", 32'h0, {31'h0, d[0]});
    set_v(V_OK);
  endtask

  task automatic t_delayed();
    int dt1[3] = '{10, 20, 40};
    wr_reg(`OUV_ADDR_ACTION, 32'h40, `OUV_AXI_OKAY);
    set_v(V_LOW);
    repeat (20) @(posedge aclk);
    set_v(V_OK);
    repeat (80) @(posedge aclk);
    check("oe short fault", 32'h1, {31'h0, oe});
    for (int c = 0; c < 3; c++) begin
      wr_reg(`OUV_ADDR_ACTION, {24'h0, 5'h08, 3'(c)}, `OUV_AXI_OKAY);
      set_v(V_LOW);
      wait_oe(1'h0, 400, n);
      in_rng("trip delay", n, dt1[c] * MS, dt1[c] * MS + 10);
      repeat (4) @(posedge aclk);
      st_chk(3'h4);
      set_v(V_OK);
      supply_drop(1'h0);
    end
    // Delayed response with one retry: trip, restart, trip again, then latched.
    wr_reg(`OUV_ADDR_ACTION, 32'h48, `OUV_AXI_OKAY);
    set_v(V_LOW);
    wait_oe(1'h0, 400, n);
    in_rng("trip before retry", n, 10 * MS, 10 * MS + 10);
    wait_oe(1'h1, 1100, n);
    in_rng("delayed restart", n, 252 * MS, 252 * MS + 12);
    wait_oe(1'h0, 400, n);
    in_rng("trip after retry", n, 10 * MS, 10 * MS + 10);
    st_chk(3'h4);
    set_v(V_OK);
    supply_drop(1'h0);
  endtask

  task automatic t_retry();
    logic [31:0] d;
    logic [1:0] r;
    check("irq masked", 32'h0, {31'h0, irq});
    wr_reg(`OUV_ADDR_ACTION, 32'h90, `OUV_AXI_OKAY);
    set_v(V_LOW);
    wait_oe(1'h0, 20, n);
    in_rng("shut now", n, 1, 6);
    repeat (2) begin
      wait_oe(1'h1, 1100, n);
      in_rng("restart gap", n, 252 * MS, 252 * MS + 12);
      wait_oe(1'h0, 20, n);
      in_rng("reshut", n, 1, 6);
    end
    repeat (1100) @(posedge aclk);
    check("oe latched", 32'h0, {31'h0, oe});
    rd_reg(`OUV_ADDR_STATE, d, r);
    check("latched state", 32'h4, {29'h0, d[4:2]});
    check("attempts", 32'h2, {29'h0, d[8:6]});
    wr_reg(`OUV_ADDR_MASK, 32'h4, `OUV_AXI_OKAY);
    @(negedge aclk);
    check("irq set", 32'h1, {31'h0, irq});
    rd_chk(`OUV_ADDR_STATUS, 32'hf, "status");
    @(negedge aclk);
    check("irq clear", 32'h0, {31'h0, irq});
    set_v(V_OK);
    supply_drop(1'h1);
  endtask

  task automatic t_infinite();
    wr_reg(`OUV_ADDR_ACTION, 32'hb8, `OUV_AXI_OKAY);
    set_v(V_LOW);
    wait_oe(1'h0, 20, n);
    in_rng("endless first shut", n, 1, 6);
    repeat (3) begin
      wait_oe(1'h1, 1100, n);
      in_rng("endless restart", n, 252 * MS, 252 * MS + 12);
      wait_oe(1'h0, 20, n);
    end
    repeat (4) @(posedge aclk);
    st_chk(3'h2);
    set_v(V_OK);
    wait_oe(1'h1, 1100, n);
    in_rng("recover", n, 1, 252 * MS + 12);
  endtask

  task automatic t_hold();
    wr_reg(`OUV_ADDR_ACTION, 32'hc0, `OUV_AXI_OKAY);
    set_v(V_LOW);
    wait_oe(1'h0, 20, n);
    in_rng("hold off", n, 1, 6);
    repeat (200) @(posedge aclk);
    check("oe held", 32'h0, {31'h0, oe});
    st_chk(3'h3);
    set_v(V_OK);
    wait_oe(1'h1, 20, n);
    in_rng("hold release", n, 1, 6);
  endtask

  task automatic t_reset();
    wr_reg(`OUV_ADDR_ACTION, 32'h80, `OUV_AXI_OKAY);
    set_v(V_LOW);
    wait_oe(1'h0, 20, n);
    in_rng("no retry off", n, 1, 6);
    repeat (20) @(posedge aclk);
    st_chk(3'h4);
    set_v(V_OK);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    wait_oe(1'h1, 30, n);
    in_rng("reset clears", n, 1, 10);
    rd_chk(`OUV_ADDR_ACTION, 32'h0, "action after reset");
  endtask

  initial begin
    aresetn = 1'h0;
    awv = 1'h0;
    wv = 1'h0;
    bready = 1'h0;
    arv = 1'h0;
    rready = 1'h0;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    ws = 4'hf;
    vm = V_OK;
    pwr = 1'h1;
    bias = 1'h1;
    bad_count = 0;
    compares = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    wait_oe(1'h1, 30, n);
    in_rng("power up", n, 1, 10);
    t_regs();
    t_ignore();
    t_delayed();
    t_retry();
    t_infinite();
    t_hold();
    t_reset();
    end_of_test();
  end
endmodule
